// File: verilog/dmu_outbound.sv
/*
  DMA unit end: builds interrupt (mondo) and read completion packets
  and sends each as a header beat followed by one payload beat.
  Assumes user requests are held until taken; the far end may stall.
*/
// How it works
// - Interrupt packet is header plus one payload beat
// - Receiver forwards full interrupt identifier unchanged
// - Interrupt packets go to ordered queue
// - Interrupt command 000001, error flags zero
// - Interrupt identifier follows receiver interrupt encoding
// - Receiver tells mondo from completion by command; identifier tag only cross-checked
// - Completion packet is header plus one payload beat
// - Receiver forwards full completion identifier and payload
// - Completions go to bypass queue
// - Receiver leaves completion byte validity uninterpreted
// - Completion command 101001, address ignored
// - Posted bit ignored when response bit set
// - Byte-mask bit ignored on response or read
// - Completion identifier is tag, credit, thread
// - Bit 62 carries command parity on completions
// - Bit 82 marks timeout, completions only
// - Bit 81 marks bad address on completions
// - Bit 80 marks uncorrectable payload on completions
`timescale 1ns/1ns
`include "pkt_defs.svh"
module dmu_outbound (
  input wire CLOCK,
  input wire NRST,
  pkt_link_if.dmu_end LINK,
  input wire INTR_REQ,
  input pkt_pkg::id_t INTR_ID,
  input pkt_pkg::beat_t INTR_MONDO,
  output logic INTR_TAKEN,
  output logic INTR_REJECT,
  input wire COMPL_REQ,
  input pkt_pkg::credit_t COMPL_CREDIT,
  input pkt_pkg::thread_t COMPL_THREAD,
  input pkt_pkg::beat_t COMPL_DATA,
  input wire COMPL_TIMED_OUT,
  input wire COMPL_BAD_ADDRESS,
  input wire COMPL_UNCORRECTABLE,
  output logic COMPL_TAKEN,
  output logic BUSY,
  output logic DONE
);
  import pkt_pkg::*;

  // ========================================
  // Header builders
  function automatic beat_t build_intr_hdr(input id_t id);
    beat_t h;
    // Reserved, flags and address all zero
    h = `BEAT_RST;
    h[`CMD_HI:`CMD_LO] = `CMD_INTR;
    // Flags spelled out: a timeout means nothing on a mondo
    h[`TIMEOUT_BIT] = 1'b0;
    h[`BAD_ADDR_BIT] = 1'b0;
    h[`UNCORR_BIT] = 1'b0;
    h[`PHYSICAL_ADDRESS_FIELD_HI:`PHYSICAL_ADDRESS_FIELD_LO] = '0;
    // Caller supplies the receiver's interrupt encoding
    h[`ID_HI:`ID_LO] = id;
    return h;
  endfunction

  function automatic beat_t build_compl_hdr(
    input credit_t credit,
    input thread_t thread,
    input logic timed_out,
    input logic bad_address,
    input logic uncorrectable
  );
    beat_t h;
    cmd_t cmd;
    id_t cid;
    cmd = `CMD_COMPL;
    h = `BEAT_RST;
    h[`CMD_HI:`CMD_LO] = cmd;
    // Address goes unused downstream, so it is sent as zero
    h[`PHYSICAL_ADDRESS_FIELD_HI:`PHYSICAL_ADDRESS_FIELD_LO] = '0;
    h[`TIMEOUT_BIT] = timed_out;
    h[`BAD_ADDR_BIT] = bad_address;
    h[`UNCORR_BIT] = uncorrectable;
    cid = `ID_RST;
    cid[`CID_TAG_HI:`CID_TAG_LO] = `CID_TAG;
    cid[`CID_CREDIT_HI:`CID_CREDIT_LO] = credit;
    cid[`CID_PAD_HI:`CID_PAD_LO] = `CID_PAD;
    cid[`CID_THREAD_HI:`CID_THREAD_LO] = thread;
    h[`ID_HI:`ID_LO] = cid;
    h[`PARITY_BIT] = ^cmd;
    return h;
  endfunction

  // ========================================
  // Request selection
  tx_state_e tx_state;
  logic idle;
  logic intr_clash;
  logic take_intr;
  logic take_compl;
  logic beat_sent;
  beat_t pay_hold;

  assign idle = tx_state == TX_IDLE;
  // A mondo tagged like a completion would be flagged malformed downstream
  assign intr_clash = INTR_ID[`CID_TAG_HI:`CID_TAG_LO] == `CID_TAG;
  // Completion wins a tie: bypass traffic is the latency-critical one
  assign take_compl = idle & COMPL_REQ;
  assign take_intr = idle & INTR_REQ & ~COMPL_REQ & ~intr_clash;
  assign COMPL_TAKEN = take_compl;
  assign INTR_TAKEN = take_intr;
  assign INTR_REJECT = idle & INTR_REQ & ~COMPL_REQ & intr_clash;
  assign BUSY = ~idle;
  // Far side ready is combinational, so both stand at one edge
  assign beat_sent = LINK.valid & LINK.ready;

  // ========================================
  // Sequencer
  // Idle always follows a payload, so packets are at least one cycle apart
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      tx_state <= TX_IDLE;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (take_compl || take_intr) begin
            tx_state <= TX_HDR;
          end
        end
        TX_HDR: begin
          if (beat_sent) begin
            tx_state <= TX_PAY;
          end
        end
        TX_PAY: begin
          if (beat_sent) begin
            tx_state <= TX_IDLE;
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ========================================
  // Link drive
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      LINK.valid <= 1'b0;
    end else if (take_compl || take_intr) begin
      LINK.valid <= 1'b1;
    end else if (tx_state == TX_PAY && beat_sent) begin
      // Held through stalls; drops only once the payload is taken
      LINK.valid <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      LINK.ordered <= 1'b0;
    end else if (take_compl) begin
      // Steering set at the take and steady for the whole packet
      LINK.ordered <= 1'b0;
    end else if (take_intr) begin
      LINK.ordered <= 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pay_hold <= `BEAT_RST;
    end else if (take_compl) begin
      // Payload latched at the take; the user may drop the request then
      pay_hold <= COMPL_DATA;
    end else if (take_intr) begin
      pay_hold <= INTR_MONDO;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      LINK.data <= `BEAT_RST;
    end else if (take_compl) begin
      // Header built from the request as it stands at the take edge
      LINK.data <= build_compl_hdr(COMPL_CREDIT, COMPL_THREAD, COMPL_TIMED_OUT,
                                   COMPL_BAD_ADDRESS, COMPL_UNCORRECTABLE);
    end else if (take_intr) begin
      LINK.data <= build_intr_hdr(INTR_ID);
    end else if (tx_state == TX_HDR && beat_sent) begin
      // Single payload beat, bytes 0 to 15
      LINK.data <= pay_hold;
    end
  end

  // ========================================
  // Completion of a packet
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      DONE <= 1'b0;
    end else begin
      // One-cycle pulse, in the cycle the receiver raises its valid
      DONE <= tx_state == TX_PAY && beat_sent;
    end
  end
endmodule

// File: verilog/pkt_defs.svh
/*
  Bit positions and encodings of the 128-bit inbound packet header.
  Assumes inclusion by bare name wherever a field is touched.
*/
`ifndef PKT_DEFS_SVH
`define PKT_DEFS_SVH
// ========================================
// Command field
`define CMD_HI 127
`define CMD_LO 122
`define RESP_BIT 127
`define POSTED_BIT 126
`define READ_BIT 125
`define MASK_BIT 124
`define L2_BIT 123
`define NCU_BIT 122
`define CMD_INTR 6'h01
`define CMD_COMPL 6'h29
// ========================================
// Flags, identifier, parity, address
`define TIMEOUT_BIT 82
`define BAD_ADDR_BIT 81
`define UNCORR_BIT 80
`define ID_HI 79
`define ID_LO 64
`define PARITY_BIT 62
`define PHYSICAL_ADDRESS_FIELD_HI 39
`define PHYSICAL_ADDRESS_FIELD_LO 0
// ========================================
// Completion identifier layout
`define CID_TAG_HI 15
`define CID_TAG_LO 13
`define CID_CREDIT_HI 12
`define CID_CREDIT_LO 9
`define CID_PAD_HI 8
`define CID_PAD_LO 6
`define CID_THREAD_HI 5
`define CID_THREAD_LO 0
`define CID_TAG 3'h4
`define CID_PAD 3'h0
// ========================================
// Reset values
`define BEAT_RST 128'h0
`define ID_RST 16'h0
`endif

// File: verilog/pkt_pkg.sv
/*
  Types shared by both ends of the inbound packet link.
  Assumes pkt_defs.svh holds every bit position and count.
*/
package pkt_pkg;
  typedef logic [127:0] beat_t;
  typedef logic [15:0] id_t;
  typedef logic [3:0] credit_t;
  typedef logic [5:0] thread_t;
  typedef logic [5:0] cmd_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_HDR = 2'b01,
    TX_PAY = 2'b11
  } tx_state_e;
  typedef enum logic {
    RX_HDR = 1'b0,
    RX_PAY = 1'b1
  } rx_state_e;
endpackage

// File: verilog/pkt_link_if.sv
/*
  Link between the DMA unit and the system interface unit.
  Assumes both ends share one clock; the bench joins the two modports.
*/
`timescale 1ns/1ns
interface pkt_link_if;
  import pkt_pkg::*;
  logic valid;
  logic ready;
  beat_t data;
  logic ordered;
  modport dmu_end (output valid, output data, output ordered, input ready);
  modport siu_end (input valid, input data, input ordered, output ready);
endinterface

// File: verilog/hdr_decode.sv
/*
  Combinational classification of one received header beat.
  Assumes the caller samples outputs only while a header beat is taken.
*/
`timescale 1ns/1ns
`include "pkt_defs.svh"
module hdr_decode (
  input pkt_pkg::beat_t hdr,
  output logic is_intr,
  output logic is_compl,
  output logic malformed,
  output logic parity_err,
  output logic timed_out,
  output logic bad_address,
  output logic uncorrectable,
  output pkt_pkg::id_t id
);
  import pkt_pkg::*;
  logic resp, read, ncu, l2, posted_seen, mask_seen, id_says_compl;
  assign resp = hdr[`RESP_BIT];
  assign read = hdr[`READ_BIT];
  assign ncu = hdr[`NCU_BIT];
  assign l2 = hdr[`L2_BIT];
  assign posted_seen = resp ? 1'b0 : hdr[`POSTED_BIT];
  assign mask_seen = (resp | read) ? 1'b0 : hdr[`MASK_BIT];
  assign id = hdr[`ID_HI:`ID_LO];
  // Identifier tag must agree with the command's completion class, else malformed
  assign id_says_compl = id[`CID_TAG_HI:`CID_TAG_LO] == `CID_TAG;
  assign is_compl = resp & read & ncu & ~l2;
  assign is_intr = ~resp & ~read & ncu & ~l2 & ~posted_seen & ~mask_seen;
  assign malformed = ~(is_compl | is_intr) | (is_compl != id_says_compl);
  assign parity_err = is_compl & (hdr[`PARITY_BIT] != ^hdr[`CMD_HI:`CMD_LO]);
  // Error flags count only on completions
  assign timed_out = is_compl & hdr[`TIMEOUT_BIT];
  assign bad_address = is_compl & hdr[`BAD_ADDR_BIT];
  assign uncorrectable = is_compl & hdr[`UNCORR_BIT];
endmodule

// File: verilog/siu_inbound.sv
/*
  System interface unit end: takes header and payload beats from the
  link and presents one packet at a time to the non-cacheable unit.
  Assumes the DMA end keeps valid and data steady until ready.
*/
`timescale 1ns/1ns
`include "pkt_defs.svh"
module siu_inbound (
  input wire CLOCK,
  input wire NRST,
  pkt_link_if.siu_end LINK,
  output logic NCU_VALID,
  input wire NCU_READY,
  output pkt_pkg::beat_t NCU_PAYLOAD,
  output pkt_pkg::id_t NCU_ID,
  output logic NCU_IS_COMPL,
  output logic NCU_ORDERED,
  output logic NCU_TIMED_OUT,
  output logic NCU_BAD_ADDRESS,
  output logic NCU_UNCORRECTABLE,
  output logic NCU_PARITY_ERR,
  output logic NCU_MALFORMED
);
  import pkt_pkg::*;
  rx_state_e rx_state;
  logic beat_taken;
  logic d_intr, d_compl, d_malformed, d_parity, d_timeout, d_bad, d_uncorr;
  id_t d_id;

  hdr_decode u_decode (
    .hdr(LINK.data),
    .is_intr(d_intr),
    .is_compl(d_compl),
    .malformed(d_malformed),
    .parity_err(d_parity),
    .timed_out(d_timeout),
    .bad_address(d_bad),
    .uncorrectable(d_uncorr),
    .id(d_id)
  );

  // ========================================
  // Link side
  // Stalls while a packet waits, so no second packet buffer is needed
  assign LINK.ready = ~NCU_VALID;
  assign beat_taken = LINK.valid & LINK.ready;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      rx_state <= RX_HDR;
    end else if (beat_taken) begin
      unique case (rx_state)
        RX_HDR: rx_state <= RX_PAY;
        RX_PAY: rx_state <= RX_HDR;
      endcase
    end
  end

  // ========================================
  // Header capture
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      NCU_ID <= `ID_RST;
      NCU_IS_COMPL <= 1'b0;
      NCU_ORDERED <= 1'b0;
      NCU_TIMED_OUT <= 1'b0;
      NCU_BAD_ADDRESS <= 1'b0;
      NCU_UNCORRECTABLE <= 1'b0;
      NCU_PARITY_ERR <= 1'b0;
      NCU_MALFORMED <= 1'b0;
    end else if (beat_taken && rx_state == RX_HDR) begin
      NCU_ID <= d_id;
      NCU_IS_COMPL <= d_compl;
      NCU_ORDERED <= LINK.ordered;
      NCU_TIMED_OUT <= d_timeout;
      NCU_BAD_ADDRESS <= d_bad;
      NCU_UNCORRECTABLE <= d_uncorr;
      NCU_PARITY_ERR <= d_parity;
      // Wrong queue is reported, not corrected
      NCU_MALFORMED <= d_malformed | (d_intr & ~LINK.ordered) | (d_compl & LINK.ordered);
    end
  end

  // ========================================
  // Payload and hand-off
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      NCU_PAYLOAD <= `BEAT_RST;
    end else if (beat_taken && rx_state == RX_PAY) begin
      // Whole beat passed on; byte enables are the requester's business
      NCU_PAYLOAD <= LINK.data;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      NCU_VALID <= 1'b0;
    end else if (beat_taken && rx_state == RX_PAY) begin
      NCU_VALID <= 1'b1;
    end else if (NCU_READY) begin
      NCU_VALID <= 1'b0;
    end
  end
endmodule

// File: tb/pkt_link_properties.sv
/*
  Link checker: header encodings, queue steering, beat handshake.
  Assumes the bench feeds the link signals in by name.
*/
`timescale 1ns/1ns
module pkt_link_properties (
  input wire CLOCK,
  input wire NRST,
  input logic valid,
  input logic ready,
  input pkt_pkg::beat_t data,
  input logic ordered
);
  import pkt_pkg::*;
  logic pay;
  logic hdr;
  cmd_t cmd;
  // ========================================
  // Beat phase, set when the next beat is a payload
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      pay <= 1'b0;
    end else if (valid && ready) begin
      pay <= !pay;
    end
  end
  assign hdr = valid && !pay;
  assign cmd = data[127:122];
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // ========================================
  // Assertions
  AST_HOLD: assert property (valid && !ready |=> valid && $stable(data) && $stable(ordered))
    else $error("beat changed while stalled");
  AST_PAY_NEXT: assert property (hdr && ready |=> valid && pay)
    else $error("no payload right after header");
  AST_GAP: assert property (valid && ready && pay |=> !valid)
    else $error("beat directly after payload");
  AST_CMD: assert property (hdr |-> cmd == 6'h01 || cmd == 6'h29)
    else $error("illegal command");
  AST_INTR: assert property (hdr && cmd == 6'h01 |-> ordered && data[82:80] == 3'h0)
    else $error("bad interrupt header");
  AST_INTR_ID: assert property (hdr && cmd == 6'h01 |-> data[79:77] != 3'h4)
    else $error("interrupt id has completion tag");
  AST_COMPL_Q: assert property (hdr && cmd == 6'h29 |-> !ordered)
    else $error("completion on ordered queue");
  AST_CID: assert property (hdr && cmd == 6'h29 |-> data[79:77] == 3'h4 && data[72:70] == 3'h0)
    else $error("bad completion id");
  AST_PARITY: assert property (hdr && cmd == 6'h29 |-> data[62] == ^cmd)
    else $error("bad command parity");
  AST_RSVD: assert property (hdr |-> data[121:83] == '0 && !data[63] && data[61:0] == '0)
    else $error("reserved bits set");
endmodule

// File: tb/tb_top.sv
/*
  Bench: DMA end and interface end on one link, plus a second
  interface end fed by hand with off-nominal headers.
  Assumes a 100 MHz clock and the design files compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  import pkt_pkg::*;
  logic CLOCK = 1'b0;
  logic NRST = 1'b0;
  logic INTR_REQ = 1'b0, COMPL_REQ = 1'b0, NCU_READY = 1'b0, ph = 1'b0;
  id_t INTR_ID = '0;
  beat_t INTR_MONDO = '0, COMPL_DATA = '0, hdr_seen, NCU_PAYLOAD;
  credit_t COMPL_CREDIT = '0;
  thread_t COMPL_THREAD = '0;
  logic [2:0] flg = 3'h0;
  logic INTR_TAKEN, INTR_REJECT, COMPL_TAKEN, BUSY, DONE, v2, c2, m2, p2;
  logic NCU_VALID, NCU_IS_COMPL, NCU_ORDERED, NCU_TIMED_OUT, NCU_BAD_ADDRESS;
  logic NCU_UNCORRECTABLE, NCU_PARITY_ERR, NCU_MALFORMED;
  id_t NCU_ID;
  int errors = 0, num_checks = 0, seed = 76, k;
  pkt_link_if u_link ();
  pkt_link_if u_link2 ();
  dmu_outbound u_dmu_outbound (.CLOCK, .NRST, .LINK(u_link.dmu_end), .INTR_REQ, .INTR_ID,
    .INTR_MONDO, .INTR_TAKEN, .INTR_REJECT, .COMPL_REQ, .COMPL_CREDIT, .COMPL_THREAD,
    .COMPL_DATA, .COMPL_TIMED_OUT(flg[2]), .COMPL_BAD_ADDRESS(flg[1]),
    .COMPL_UNCORRECTABLE(flg[0]), .COMPL_TAKEN, .BUSY, .DONE);
  siu_inbound u_siu_inbound (.CLOCK, .NRST, .LINK(u_link.siu_end), .NCU_VALID, .NCU_READY,
    .NCU_PAYLOAD, .NCU_ID, .NCU_IS_COMPL, .NCU_ORDERED, .NCU_TIMED_OUT, .NCU_BAD_ADDRESS,
    .NCU_UNCORRECTABLE, .NCU_PARITY_ERR, .NCU_MALFORMED);
  siu_inbound u_siu_inbound_2 (.CLOCK, .NRST, .LINK(u_link2.siu_end), .NCU_VALID(v2),
    .NCU_READY, .NCU_PAYLOAD(), .NCU_ID(), .NCU_IS_COMPL(c2), .NCU_ORDERED(),
    .NCU_TIMED_OUT(), .NCU_BAD_ADDRESS(), .NCU_UNCORRECTABLE(), .NCU_PARITY_ERR(p2),
    .NCU_MALFORMED(m2));
  pkt_link_properties u_props (.CLOCK, .NRST, .valid(u_link.valid), .ready(u_link.ready),
    .data(u_link.data), .ordered(u_link.ordered));
  always #5 CLOCK = ~CLOCK;
  // Random stalls from the far side
  always @(posedge CLOCK) NCU_READY <= 1'($random(seed));
  always @(posedge CLOCK) begin
    if (u_link.valid && u_link.ready) begin
      ph <= !ph;
      if (!ph) hdr_seen <= u_link.data;
    end
  end
  // ========================================
  // Expectations and comparisons
  function automatic beat_t exp_hdr(input logic c, input id_t id, input logic [2:0] f);
    beat_t h;
    h = '0;
    h[127:122] = c ? 6'h29 : 6'h01;
    h[82:80] = c ? f : 3'h0;
    h[79:64] = id;
    h[62] = c & ^h[127:122];
    return h;
  endfunction
  task automatic chk_beat(input beat_t got, input beat_t exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t beat %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %0t bits %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ========================================
  // One packet end to end
  task automatic pkt(input logic c, input id_t id, input beat_t pay, input logic [2:0] f);
    int n;
    @(posedge CLOCK);
    COMPL_REQ <= c;
    INTR_REQ <= !c;
    INTR_ID <= id;
    INTR_MONDO <= pay;
    COMPL_CREDIT <= id[12:9];
    COMPL_THREAD <= id[5:0];
    COMPL_DATA <= pay;
    flg <= f;
    @(negedge CLOCK);
    chk_bits({13'h0, COMPL_TAKEN, INTR_TAKEN, INTR_REJECT}, {13'h0, c, !c, 1'b0});
    @(posedge CLOCK);
    COMPL_REQ <= 1'b0;
    INTR_REQ <= 1'b0;
    @(negedge CLOCK);
    chk_bits({15'h0, BUSY}, 16'h1);
    n = 0;
    while (NCU_VALID !== 1'b1 && n < 50) begin
      @(negedge CLOCK);
      n++;
    end
    chk_bits({13'h0, NCU_VALID, DONE, BUSY}, 16'h6);
    chk_beat(hdr_seen, exp_hdr(c, id, f));
    chk_beat(NCU_PAYLOAD, pay);
    chk_bits(NCU_ID, id);
    chk_bits({12'h0, NCU_IS_COMPL, NCU_ORDERED, NCU_MALFORMED, NCU_PARITY_ERR},
      {12'h0, c, !c, 2'b00});
    chk_bits({13'h0, NCU_TIMED_OUT, NCU_BAD_ADDRESS, NCU_UNCORRECTABLE},
      {13'h0, f});
    while (NCU_VALID === 1'b1 && n < 100) begin
      @(negedge CLOCK);
      n++;
    end
    chk_bits({15'h0, NCU_VALID}, 16'h0);
  endtask
  // Hand-made header into the second interface end
  task automatic drv2(input beat_t h, input logic o, input logic [2:0] exp);
    int n;
    @(posedge CLOCK);
    u_link2.valid <= 1'b1;
    u_link2.data <= h;
    u_link2.ordered <= o;
    @(posedge CLOCK);
    u_link2.data <= ~h;
    @(posedge CLOCK);
    u_link2.valid <= 1'b0;
    n = 0;
    while (v2 !== 1'b1 && n < 20) begin
      @(negedge CLOCK);
      n++;
    end
    chk_bits({12'h0, v2, c2, m2, p2}, {12'h0, 1'b1, exp});
    while (v2 === 1'b1 && n < 100) begin
      @(negedge CLOCK);
      n++;
    end
    chk_bits({15'h0, v2}, 16'h0);
  endtask
  initial begin
    beat_t h;
    logic [31:0] r;
    id_t id;
    u_link2.valid = 1'b0;
    u_link2.data = '0;
    u_link2.ordered = 1'b0;
    repeat (20) @(posedge CLOCK);
    NRST <= 1'b1;
    pkt(1'b1, 16'h9e3f, '1, 3'h7);
    pkt(1'b0, 16'h7fff, '0, 3'h0);
    for (k = 0; k < 40; k++) begin
      r = $random(seed);
      id = r[0] ? {3'h4, r[12:9], 3'h0, r[5:0]} : {(r[15:13] == 3'h4) ? 3'h0 : r[15:13], r[12:0]};
      pkt(r[0], id, {$random(seed), $random(seed), $random(seed), $random(seed)},
        r[0] ? r[18:16] : 3'h0);
    end
    @(posedge CLOCK);
    INTR_ID <= 16'h8000;
    INTR_REQ <= 1'b1;
    @(negedge CLOCK);
    chk_bits({14'h0, INTR_REJECT, INTR_TAKEN}, 16'h2);
    @(posedge CLOCK);
    INTR_REQ <= 1'b0;
    @(negedge CLOCK);
    chk_bits({15'h0, BUSY}, 16'h0);
    h = exp_hdr(1'b1, 16'h8000, 3'h0);
    h[126] = 1'b1;
    h[124] = 1'b1;
    h[62] = ^h[127:122];
    drv2(h, 1'b0, 3'b100);
    drv2(exp_hdr(1'b0, 16'h0001, 3'h0), 1'b0, 3'b010);
    drv2(exp_hdr(1'b1, 16'h8000, 3'h0), 1'b1, 3'b110);
    h = exp_hdr(1'b1, 16'h8000, 3'h0);
    h[62] = 1'b0;
    drv2(h, 1'b0, 3'b101);
    summarize();
  end
  initial begin
    #300000;
    errors++;
    summarize();
  end
endmodule
